// ---- src/sbrg_top.v ----
`timescale 1ns/1ps
`include "sbrg_defines.vh"

// Contract
// - source select picks master clock, master clock over 8, or external pin
// - selected clock divided by 16-bit counter loaded from divisor value
// - divisor zero stops all sampling and bit clock pulses, except external source in sync or spi, which passes undivided
// - divisor one bypasses divider, selected clock passes undivided, except spi with internal source, floored to divisor 4
// - async: divided clock is the receiver sampling clock
// - async: bit clock is sampling clock over 8 if oversample set, else 16
// - async bit rate is selected clock over 8*(2-over)*divisor
// - spi: receive pin is master-in when master, master-out when slave
// - spi slave: clear-to-send input is the slave select
// - spi master: request-to-send output drives slave select
// - spi serial clock from an internal source no faster than master clock over four
// - clock gating resumes from exactly the held state
// - configuration accepted while peripheral clock is gated
// - sync or spi with internal source: bit clock is selected clock over the effective divisor only
// - source 3 is external pin; sync mode uses it undivided
module sbrg_top (
    input wire core_clk,
    input wire rst,
    input wire clk_gate_en,
    input wire cfg_wr,
    input wire [1:0] clock_source_select_in,
    input wire [`SBRG_CD_W-1:0] divisor_value_in,
    input wire over_in,
    input wire [1:0] mode_in,
    input wire spi_master_in,
    input wire ext_clk_in,
    input wire rxd_in,
    input wire cts_n_in,
    input wire tx_data_in,
    input wire rx_mosi_from_core,
    input wire slave_sel_req,
    output reg sample_tick,
    output reg bit_tick,
    output reg txd_out,
    output reg rts_n_out,
    output reg rx_data_out,
    output reg slave_select_n_out
);
    reg [1:0] src_reg;
    reg [`SBRG_CD_W-1:0] cd_reg;
    reg over_reg;
    reg [1:0] mode_reg;
    reg master_reg;
    reg [`SBRG_MCK_DIV_W-1:0] pre_reg;
    reg [`SBRG_CD_W-1:0] cnt_reg;
    reg [4:0] ovs_reg;
    wire ext_rise;
    reg src_tick;
    reg div_tick;
    reg [`SBRG_CD_W-1:0] cd_eff;
    wire is_async;
    wire is_spi;
    wire ext_direct;
    reg [4:0] ovs_max;
    wire pre_wrap;
    wire cnt_reload;
    wire ovs_wrap;
    wire spi_floor;
    wire spi_slave;
    wire spi_master;
    reg [1:0] div_mode;

    localparam DIV_OFF = 2'h0;
    localparam DIV_PASS = 2'h1;
    localparam DIV_COUNT = 2'h2;
    localparam DIV_DIRECT = 2'h3;

    sbrg_ext_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .ext_clk_in(ext_clk_in),
        .ext_rise(ext_rise)
    );

    assign is_async = (mode_reg == `SBRG_MODE_ASYNC);
    assign is_spi = (mode_reg == `SBRG_MODE_SPI);
    assign ext_direct = (src_reg == `SBRG_SRC_EXT) && !is_async;
    assign spi_slave = is_spi && !master_reg;
    assign spi_master = is_spi && master_reg;
    assign pre_wrap = (pre_reg == `SBRG_MCK_DIV - 4'h1);
    // a shrunken divisor must not run down from the old, larger count
    assign cnt_reload = (cnt_reg <= 16'h0001) || (cnt_reg > cd_eff);
    assign ovs_wrap = (ovs_reg >= ovs_max);
    // spi with internal source never faster than master clock / 4
    assign spi_floor = is_spi
        && (src_reg != `SBRG_SRC_EXT)
        && (cd_reg != 16'h0000)
        && (cd_reg < `SBRG_SPI_MIN_DIV);

    // last oversample count before the bit tick
    always @* begin
        if (over_reg) begin
            ovs_max = `SBRG_OVS8 - 5'h01;
        end else begin
            ovs_max = `SBRG_OVS16 - 5'h01;
        end
    end

    // config fields; writes need no gate enable
    always @(posedge core_clk) begin
        if (rst) begin
            src_reg <= `SBRG_SRC_MCK;
        end else if (cfg_wr) begin
            src_reg <= clock_source_select_in;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            cd_reg <= `SBRG_CD_RST;
        end else if (cfg_wr) begin
            cd_reg <= divisor_value_in;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            over_reg <= 1'b0;
        end else if (cfg_wr) begin
            over_reg <= over_in;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            mode_reg <= `SBRG_MODE_ASYNC;
        end else if (cfg_wr) begin
            mode_reg <= mode_in;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            master_reg <= 1'b0;
        end else if (cfg_wr) begin
            master_reg <= spi_master_in;
        end
    end

    // source tick select
    always @* begin
        case (src_reg)
            `SBRG_SRC_MCK: src_tick = 1'b1;
            `SBRG_SRC_MCKDIV: src_tick = pre_wrap;
            `SBRG_SRC_EXT: src_tick = ext_rise;
            default: src_tick = 1'b0;
        endcase
    end

    // effective divisor after the spi floor
    always @* begin
        cd_eff = cd_reg;
        if (spi_floor) begin
            cd_eff = `SBRG_SPI_MIN_DIV;
        end
    end

    // divider class: off, bypass, counting, or external direct
    always @* begin
        if (ext_direct) begin
            div_mode = DIV_DIRECT;
        end else if (cd_eff == 16'h0000) begin
            div_mode = DIV_OFF;
        end else if (cd_eff == 16'h0001) begin
            div_mode = DIV_PASS;
        end else begin
            div_mode = DIV_COUNT;
        end
    end

    always @* begin
        case (div_mode)
            DIV_OFF: div_tick = 1'b0;
            DIV_PASS: div_tick = src_tick;
            DIV_COUNT: div_tick = src_tick && (cnt_reg == 16'h0001);
            DIV_DIRECT: div_tick = src_tick;
            default: div_tick = 1'b0;
        endcase
    end

    // free-running master clock prescaler; prescaler, divisor and oversample counters hold while gated
    always @(posedge core_clk) begin
        if (rst) begin
            pre_reg <= 4'h0;
        end else if (clk_gate_en && pre_wrap) begin
            pre_reg <= 4'h0;
        end else if (clk_gate_en) begin
            pre_reg <= pre_reg + 4'h1;
        end
    end

    // divisor down-counter
    always @(posedge core_clk) begin
        if (rst) begin
            cnt_reg <= 16'h0000;
        end else if (clk_gate_en && src_tick) begin
            if (cnt_reload) begin
                cnt_reg <= cd_eff;
            end else begin
                cnt_reg <= cnt_reg - 16'h0001;
            end
        end
    end

    // oversample counter, async only
    always @(posedge core_clk) begin
        if (rst) begin
            ovs_reg <= 5'h00;
        end else if (clk_gate_en) begin
            if (!is_async) begin
                ovs_reg <= 5'h00;
            end else if (div_tick && ovs_wrap) begin
                ovs_reg <= 5'h00;
            end else if (div_tick) begin
                ovs_reg <= ovs_reg + 5'h01;
            end
        end
    end

    // registered sampling tick
    always @(posedge core_clk) begin
        if (rst) begin
            sample_tick <= 1'b0;
        end else if (clk_gate_en) begin
            sample_tick <= div_tick && is_async;
        end else begin
            sample_tick <= 1'b0;
        end
    end

    // registered bit tick
    always @(posedge core_clk) begin
        if (rst) begin
            bit_tick <= 1'b0;
        end else if (!clk_gate_en) begin
            bit_tick <= 1'b0;
        end else if (is_async) begin
            bit_tick <= div_tick && ovs_wrap;
        end else begin
            bit_tick <= div_tick;
        end
    end

    // receive pin: data in for every role
    always @(posedge core_clk) begin
        if (rst) begin
            rx_data_out <= 1'b1;
        end else begin
            rx_data_out <= rxd_in;
        end
    end

    // transmit pin: master-out in spi master, else transmit data
    always @(posedge core_clk) begin
        if (rst) begin
            txd_out <= 1'b1;
        end else if (spi_master) begin
            txd_out <= rx_mosi_from_core;
        end else begin
            txd_out <= tx_data_in;
        end
    end

    // clear-to-send becomes slave select in spi slave
    always @(posedge core_clk) begin
        if (rst) begin
            slave_select_n_out <= 1'b1;
        end else if (spi_slave) begin
            slave_select_n_out <= cts_n_in;
        end else begin
            slave_select_n_out <= 1'b1;
        end
    end

    // request-to-send drives slave select in spi master
    always @(posedge core_clk) begin
        if (rst) begin
            rts_n_out <= 1'b1;
        end else if (spi_slave) begin
            rts_n_out <= 1'b1;
        end else begin
            rts_n_out <= ~slave_sel_req;
        end
    end
endmodule

// ---- src/sbrg_defines.vh ----
`ifndef SBRG_DEFINES_VH
`define SBRG_DEFINES_VH

// clock source select codes
`define SBRG_SRC_MCK 2'h0
`define SBRG_SRC_MCKDIV 2'h1
`define SBRG_SRC_EXT 2'h3
// fixed master clock prescale factor
`define SBRG_MCK_DIV 4'h8
`define SBRG_MCK_DIV_W 4
// divisor width and reset value
`define SBRG_CD_W 16
`define SBRG_CD_RST 16'h0000
// oversampling factors, async mode
`define SBRG_OVS8 5'h08
`define SBRG_OVS16 5'h10
// spi clock floor: master clock / 4
`define SBRG_SPI_MIN_DIV 16'h0004
// operating modes
`define SBRG_MODE_ASYNC 2'h0
`define SBRG_MODE_SYNC 2'h1
`define SBRG_MODE_SPI 2'h2

`endif

// ---- src/sbrg_ext_sync.v ----
`timescale 1ns/1ps

// brings the external serial clock pin into core_clk, flags rising edges
module sbrg_ext_sync (
    input wire core_clk,
    input wire rst,
    input wire ext_clk_in,
    output reg ext_rise
);
    reg sync1_reg;
    reg sync2_reg;
    reg last_reg;

    always @(posedge core_clk) begin
        if (rst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg <= 1'b0;
            ext_rise <= 1'b0;
        end else begin
            sync1_reg <= ext_clk_in;
            sync2_reg <= sync1_reg;
            last_reg <= sync2_reg;
            ext_rise <= sync2_reg & ~last_reg;
        end
    end
endmodule

// ---- test/sbrg_ext_src.sv ----
`timescale 1ns/1ps
module sbrg_ext_src (
    input wire en,
    output reg sck
);
    initial sck = 1'b0;
    // 32 ns phases, parked low when idle
    always begin
        #32;
        sck = en ? !sck : 1'b0;
    end
endmodule

// ---- test/sbrg_monitor.sv ----
`timescale 1ns/1ps
module sbrg_monitor (
    input wire core_clk,
    input wire rst,
    input wire clk_gate_en,
    input wire cfg_wr,
    input wire [1:0] clock_source_select_in,
    input wire [15:0] divisor_value_in,
    input wire over_in,
    input wire [1:0] mode_in,
    input wire spi_master_in,
    input wire rxd_in,
    input wire cts_n_in,
    input wire tx_data_in,
    input wire rx_mosi_from_core,
    input wire slave_sel_req,
    input wire sample_tick,
    input wire bit_tick,
    input wire txd_out,
    input wire rts_n_out,
    input wire rx_data_out,
    input wire slave_select_n_out
);
    reg [1:0] md_reg, sr_reg;
    reg [15:0] cd_reg;
    reg ov_reg, ms_reg;
    wire spi = md_reg == 2'h2;
    wire ok8 = clk_gate_en && md_reg == 2'h0 && sr_reg == 2'h0 && cd_reg == 16'h0001;
    wire tx_want = (spi && ms_reg) ? rx_mosi_from_core : tx_data_in;
    always @(posedge core_clk) begin
        if (rst)
            {md_reg, sr_reg, cd_reg, ov_reg, ms_reg} <= 22'h0;
        else if (cfg_wr)
            {md_reg, sr_reg, cd_reg, ov_reg, ms_reg} <= {mode_in,
                clock_source_select_in, divisor_value_in, over_in, spi_master_in};
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_zero_div_quiet: assert property ((cd_reg == 16'h0 && md_reg == 2'h0)[*4] |-> !bit_tick && !sample_tick)
        else $error("zero cd tick");
    a_bypass_every: assert property (ok8[*4] |-> sample_tick)
        else $error("bypass gap");
    a_ovs8_spacing: assert property (bit_tick && ok8 && ov_reg |=> (!bit_tick)[*7] ##1 bit_tick)
        else $error("x8 spacing");
    a_rx_follow: assert property (clk_gate_en |=> rx_data_out == $past(rxd_in))
        else $error("rx path");
    a_txd_role: assert property (clk_gate_en |=> txd_out == $past(tx_want))
        else $error("txd role");
    a_rts_select: assert property (spi && ms_reg && clk_gate_en |=> rts_n_out == !$past(slave_sel_req))
        else $error("rts select");
    a_cts_select: assert property (spi && !ms_reg && clk_gate_en |=> slave_select_n_out == $past(cts_n_in))
        else $error("cts select");
    a_gate_freeze: assert property ((!clk_gate_en)[*3] |-> !sample_tick && !bit_tick)
        else $error("gated tick");
    c_bypass: cover property (ok8 && bit_tick);
    c_spi_master: cover property (spi && ms_reg && bit_tick);
    c_gated_cfg: cover property (!clk_gate_en && cfg_wr);
endmodule
bind sbrg_top sbrg_monitor mon (.*);

// ---- test/sbrg_top_test.sv ----
`timescale 1ns/1ps
module sbrg_top_test;
    reg core_clk, rst, clk_gate_en, cfg_wr, over_in, spi_master_in, ext_en;
    reg [1:0] clock_source_select_in, mode_in;
    reg [15:0] divisor_value_in;
    reg [4:0] pat = 5'h00;
    reg [8:0] ns, nb;
    wire rxd_in = pat[4], cts_n_in = pat[3], tx_data_in = pat[2];
    wire rx_mosi_from_core = pat[1], slave_sel_req = pat[0];
    wire ext_clk_in, sample_tick, bit_tick, txd_out, rts_n_out, rx_data_out, slave_select_n_out;
    int error_cnt = 0, checks = 0;
    // mode src cd over master gate keep samples bits, per 256 cycles
    int tb [11][9] = '{'{0,0,1,1,0,1,0,256,32}, '{0,0,2,0,0,1,0,128,8}, '{0,1,1,1,0,1,0,32,4},
        '{0,0,0,0,0,1,0,0,0}, '{0,3,1,1,0,1,0,32,4}, '{1,0,8,0,0,1,0,0,32}, '{2,0,1,0,1,1,0,0,64},
        '{2,0,2,0,0,1,0,0,64}, '{1,3,0,0,0,1,0,0,32}, '{0,0,1,1,0,0,0,0,0}, '{0,0,1,1,0,1,1,256,32}};
    sbrg_top uut (.*);
    sbrg_ext_src ext (.en(ext_en), .sck(ext_clk_in));
    // no interrupt line leaves the block; a host would sample it as a level
    always @(posedge core_clk) pat <= pat + 5'h3;
    task check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: got %0d want %0d", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task run(input int i);
        @(posedge core_clk);
        clk_gate_en <= tb[i][5][0];
        ext_en <= tb[i][1] == 3;
        if (tb[i][6] == 0) begin
            rst <= 1'b1;
            repeat (5) @(posedge core_clk);
            rst <= 1'b0;
            cfg_wr <= 1'b1;
            {mode_in, clock_source_select_in} <= {tb[i][0][1:0], tb[i][1][1:0]};
            divisor_value_in <= tb[i][2][15:0];
            {over_in, spi_master_in} <= {tb[i][3][0], tb[i][4][0]};
            @(posedge core_clk);
            cfg_wr <= 1'b0;
        end
        repeat (32) @(posedge core_clk);
        {ns, nb} = 18'h0;
        repeat (256) begin
            @(negedge core_clk);
            ns = ns + sample_tick;
            nb = nb + bit_tick;
        end
        check(ns, tb[i][7][8:0]);
        check(nb, tb[i][8][8:0]);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        error_cnt++;
        final_report;
    end
    initial begin
        {rst, clk_gate_en, cfg_wr, over_in, spi_master_in, ext_en} = 6'h20;
        {clock_source_select_in, mode_in, divisor_value_in} = 20'h0;
        for (int i = 0; i < 11; i++) run(i);
        final_report;
    end
endmodule
